/* design/lbp_pkg.sv */
`default_nettype none
package lbp_pkg;
  localparam logic [7:0] ADDR_SWING = 8'h18;
  localparam logic [7:0] ADDR_BIAS = 8'h19;
  localparam logic [7:0] ADDR_CPSCALE = 8'h1a;
  localparam logic [7:0] ADDR_CAL = 8'h1b;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;

  localparam logic [1:0] RST_PRE_SWING = 2'h3;
  localparam logic [2:0] RST_RX_SWING = 3'h4;
  localparam logic [2:0] RST_TX_SWING = 3'h1;
  localparam logic [1:0] RST_PRE_CURRENT = 2'h1;
  localparam logic [2:0] RST_RX_CURRENT = 3'h4;
  localparam logic [2:0] RST_TX_CURRENT = 3'h5;
  localparam logic [7:0] RST_CPSCALE = 8'h86;
  localparam logic [2:0] RST_DAC_SEED = 3'h5;

  localparam int POS_PRE = 6;
  localparam int POS_RX = 3;
  localparam int POS_TX = 0;
  localparam int POS_CAL_START = 7;
  localparam int POS_CAL_DUAL = 6;
  localparam int POS_CAL_WAIT = 4;
  localparam int POS_CAL_SEED = 0;

  localparam int CAL_WAIT_0 = 90000;
  localparam int CAL_WAIT_1 = 110000;
  localparam int CAL_WAIT_2 = 130000;
  localparam int CAL_WAIT_3 = 200000;
  localparam int REF_DIV = 8;

  typedef enum logic [0:0] {LBP_IDLE, LBP_RUN} lbp_state_t;
endpackage
`default_nettype wire

/* design/lbp_ref_tick.sv */
`timescale 1ns/10ps
`default_nettype none
// divides the system clock down to one-cycle reference-period enables
module lbp_ref_tick #(
  parameter int DIV = lbp_pkg::REF_DIV
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_restart,
  output logic o_tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  logic [CW-1:0] cnt_reg;

  if (DIV < 1) begin : g_div_chk
    $error("DIV must be at least 1");
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= '0;
    end else if (i_restart || cnt_reg == CW'(DIV - 1)) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= !i_restart && cnt_reg == CW'(DIV - 1);
    end
  end
endmodule
`default_nettype wire

/* design/lbp_regs.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// RL1: prescaler swing bits 7:6, reset 3
// RL2: rx lo swing bits 5:3, reset 4
// RL3: tx lo swing bits 2:0, reset 1
// RL4: prescaler current bits 7:6, reset 1
// RL5: rx lo current bits 5:3, reset 4
// RL6: tx lo current bits 2:0, reset 5
// RL7: charge-pump scale byte, reset 134
// RL8: rising start bit begins calibration
// RL9: dual bit stores results in both slots
// RL10: wait code picks 90k-200k reference periods
// RL11: host picks code 3 for accuracy
// RL12: low bits seed dac, reset 5
// RL13: count duration, store result, go idle
module lbp_regs #(
  parameter int REF_DIV = lbp_pkg::REF_DIV,
  parameter int WAIT0 = lbp_pkg::CAL_WAIT_0,
  parameter int WAIT1 = lbp_pkg::CAL_WAIT_1,
  parameter int WAIT2 = lbp_pkg::CAL_WAIT_2,
  parameter int WAIT3 = lbp_pkg::CAL_WAIT_3
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_slot_sel,
  output logic [7:0] o_rdata,
  output logic [1:0] o_pre_swing,
  output logic [2:0] o_rx_swing,
  output logic [2:0] o_tx_swing,
  output logic [1:0] o_pre_current,
  output logic [2:0] o_rx_current,
  output logic [2:0] o_tx_current,
  output logic [7:0] o_cp_scale,
  output logic o_cal_busy,
  output logic [2:0] o_dac_seed,
  output logic o_store_a,
  output logic o_store_b
);
  localparam int CW = 18;

  if (WAIT0 < 1 || WAIT1 < 1 || WAIT2 < 1 || WAIT3 < 1) begin : g_wait_pos
    $error("wait counts must be positive");
  end
  if (WAIT0 >= (1 << CW) || WAIT1 >= (1 << CW) || WAIT2 >= (1 << CW) ||
    WAIT3 >= (1 << CW)) begin : g_wait_fit
    $error("wait count exceeds counter width");
  end

  logic [7:0] swing_reg;
  logic [7:0] bias_reg;
  logic [7:0] cal_reg;
  logic slot_s1_reg, slot_s2_reg, slot_s3_reg;
  logic slot_reg;
  logic [CW-1:0] cnt_reg;
  logic done_reg;
  logic [1:0] wait_lat_reg;
  logic dual_lat_reg;
  lbp_pkg::lbp_state_t state_reg;
  logic ref_tick;
  logic start_edge;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic [CW-1:0] wait_len(input logic [1:0] code);
    unique case (code)
      2'd0: wait_len = CW'(WAIT0);
      2'd1: wait_len = CW'(WAIT1);
      2'd2: wait_len = CW'(WAIT2);
      2'd3: wait_len = CW'(WAIT3);
    endcase
  endfunction

  // start only on a 0-to-1 write of the start bit
  assign start_edge = i_wr && hit(i_addr, lbp_pkg::ADDR_CAL) &&
    i_wdata[lbp_pkg::POS_CAL_START] && !cal_reg[lbp_pkg::POS_CAL_START]; // [RL8]

  lbp_ref_tick #(.DIV(REF_DIV)) u_tick (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_restart(start_edge),
    .o_tick(ref_tick)
  );

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      swing_reg <= {lbp_pkg::RST_PRE_SWING, lbp_pkg::RST_RX_SWING, lbp_pkg::RST_TX_SWING}; // [RL1] [RL2] [RL3]
    end else if (i_wr && hit(i_addr, lbp_pkg::ADDR_SWING)) begin
      swing_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bias_reg <= {lbp_pkg::RST_PRE_CURRENT, lbp_pkg::RST_RX_CURRENT,
        lbp_pkg::RST_TX_CURRENT}; // [RL4] [RL5] [RL6]
    end else if (i_wr && hit(i_addr, lbp_pkg::ADDR_BIAS)) begin
      bias_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cp_scale <= lbp_pkg::RST_CPSCALE; // [RL7]
    end else if (i_wr && hit(i_addr, lbp_pkg::ADDR_CPSCALE)) begin
      o_cp_scale <= i_wdata;
    end
  end

  // reserved bit 3 always held at zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cal_reg <= {5'h00, lbp_pkg::RST_DAC_SEED}; // [RL12]
    end else if (i_wr && hit(i_addr, lbp_pkg::ADDR_CAL)) begin
      cal_reg <= {i_wdata[7:4], 1'b0, i_wdata[2:0]};
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pre_swing <= lbp_pkg::RST_PRE_SWING;
      o_rx_swing <= lbp_pkg::RST_RX_SWING;
      o_tx_swing <= lbp_pkg::RST_TX_SWING;
      o_pre_current <= lbp_pkg::RST_PRE_CURRENT;
      o_rx_current <= lbp_pkg::RST_RX_CURRENT;
      o_tx_current <= lbp_pkg::RST_TX_CURRENT;
      o_dac_seed <= lbp_pkg::RST_DAC_SEED;
    end else begin
      o_pre_swing <= swing_reg[lbp_pkg::POS_PRE +: 2]; // [RL1]
      o_rx_swing <= swing_reg[lbp_pkg::POS_RX +: 3]; // [RL2]
      o_tx_swing <= swing_reg[lbp_pkg::POS_TX +: 3]; // [RL3]
      o_pre_current <= bias_reg[lbp_pkg::POS_PRE +: 2]; // [RL4]
      o_rx_current <= bias_reg[lbp_pkg::POS_RX +: 3]; // [RL5]
      o_tx_current <= bias_reg[lbp_pkg::POS_TX +: 3]; // [RL6]
      o_dac_seed <= cal_reg[lbp_pkg::POS_CAL_SEED +: 3]; // [RL12]
    end
  end

  // slot select comes from another register block, treat as foreign
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      slot_s1_reg <= 1'b0;
      slot_s2_reg <= 1'b0;
      slot_s3_reg <= 1'b0;
      slot_reg <= 1'b0;
    end else begin
      slot_s1_reg <= i_slot_sel;
      slot_s2_reg <= slot_s1_reg;
      slot_s3_reg <= slot_s2_reg;
      if (slot_s2_reg == slot_s3_reg) begin
        slot_reg <= slot_s3_reg;
      end
    end
  end

  // settings latched at start so a mid-run rewrite cannot stretch the run
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_lat_reg <= 2'h0;
      dual_lat_reg <= 1'b0;
    end else if (start_edge) begin
      wait_lat_reg <= i_wdata[lbp_pkg::POS_CAL_WAIT +: 2]; // [RL10]
      dual_lat_reg <= i_wdata[lbp_pkg::POS_CAL_DUAL]; // [RL9]
    end
  end

  // a new rising edge while running restarts the count
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= lbp_pkg::LBP_IDLE;
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        lbp_pkg::LBP_IDLE: begin
          if (start_edge) begin
            state_reg <= lbp_pkg::LBP_RUN; // [RL8]
            cnt_reg <= '0;
          end
        end
        lbp_pkg::LBP_RUN: begin
          if (start_edge) begin
            cnt_reg <= '0;
          end else if (ref_tick) begin
            if (cnt_reg == wait_len(wait_lat_reg) - 1'b1) begin
              state_reg <= lbp_pkg::LBP_IDLE; // [RL13]
              done_reg <= 1'b1;
            end else begin
              cnt_reg <= cnt_reg + 1'b1; // [RL10]
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cal_busy <= 1'b0;
      o_store_a <= 1'b0;
      o_store_b <= 1'b0;
    end else begin
      o_cal_busy <= (state_reg == lbp_pkg::LBP_RUN) && !done_reg && !(ref_tick &&
        cnt_reg == wait_len(wait_lat_reg) - 1'b1 && !start_edge);
      o_store_a <= done_reg && (dual_lat_reg || !slot_reg); // [RL9] [RL13]
      o_store_b <= done_reg && (dual_lat_reg || slot_reg); // [RL9] [RL13]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (1'b1)
        hit(i_addr, lbp_pkg::ADDR_SWING): o_rdata <= swing_reg;
        hit(i_addr, lbp_pkg::ADDR_BIAS): o_rdata <= bias_reg;
        hit(i_addr, lbp_pkg::ADDR_CPSCALE): o_rdata <= o_cp_scale;
        hit(i_addr, lbp_pkg::ADDR_CAL): o_rdata <= cal_reg;
        hit(i_addr, lbp_pkg::ADDR_STATUS): o_rdata <= {7'h00, o_cal_busy};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

/* testbench/lbp_host.sv */
`timescale 1ns/10ps
`default_nettype none
// host side of the register port
module lbp_host (
  input wire logic i_clk,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  output logic o_slot_sel
);
  initial {o_addr, o_wdata, o_wr, o_rd, o_slot_sel} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    o_rd <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= ~o_wdata;
    o_wr <= 1'b0;
    o_rd <= 1'b1;
  endtask
  // idle lines toggle so a stale address never looks valid
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_addr <= ~o_addr;
      o_wr <= 1'b0;
      o_rd <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* testbench/lbp_regs_props.sv */
`timescale 1ns/10ps
`default_nettype none
module lbp_regs_props (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic [1:0] o_pre_swing,
  input wire logic [2:0] o_rx_swing,
  input wire logic [2:0] o_tx_swing,
  input wire logic [1:0] o_pre_current,
  input wire logic [2:0] o_rx_current,
  input wire logic [2:0] o_tx_current,
  input wire logic [7:0] o_cp_scale,
  input wire logic o_cal_busy,
  input wire logic [2:0] o_dac_seed,
  input wire logic o_store_a,
  input wire logic o_store_b
);
  logic start_reg;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) start_reg <= 1'b0;
    else if (i_wr && i_addr == 8'h1b) start_reg <= i_wdata[7];
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  property p_rst; $fell(i_rst) |-> {o_pre_swing, o_rx_swing, o_tx_swing, o_pre_current,
    o_rx_current, o_tx_current, o_cp_scale, o_dac_seed} == 27'h70b_2c35; endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_swing; i_wr && i_addr == 8'h18 |-> ##2
    {o_pre_swing, o_rx_swing, o_tx_swing} == $past(i_wdata, 2); endproperty
  a_swing: assert property (p_swing) else $error("swing write lost");
  property p_bias; i_wr && i_addr == 8'h19 |-> ##2
    {o_pre_current, o_rx_current, o_tx_current} == $past(i_wdata, 2); endproperty
  a_bias: assert property (p_bias) else $error("bias write lost");
  property p_cp; i_wr && i_addr == 8'h1a |=> o_cp_scale == $past(i_wdata); endproperty
  a_cp: assert property (p_cp) else $error("scale write lost");
  property p_seed; i_wr && i_addr == 8'h1b |-> ##2 o_dac_seed == $past(i_wdata[2:0], 2);
  endproperty
  a_seed: assert property (p_seed) else $error("seed write lost");
  property p_start; i_wr && i_addr == 8'h1b && i_wdata[7] && !start_reg |-> ##2 o_cal_busy;
  endproperty
  a_start: assert property (p_start) else $error("start edge ignored");
  property p_dur; $rose(o_cal_busy) |-> o_cal_busy[*6] ##[1:30] !o_cal_busy; endproperty
  a_dur: assert property (p_dur) else $error("run length wrong");
  property p_store; (o_store_a || o_store_b) == ($past(o_cal_busy, 2) && !$past(o_cal_busy));
  endproperty
  a_store: assert property (p_store) else $error("store pulse misplaced");
endmodule
bind lbp_regs lbp_regs_props lbp_regs_props_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .o_pre_swing(o_pre_swing), .o_rx_swing(o_rx_swing),
  .o_tx_swing(o_tx_swing), .o_pre_current(o_pre_current), .o_rx_current(o_rx_current),
  .o_tx_current(o_tx_current), .o_cp_scale(o_cp_scale), .o_cal_busy(o_cal_busy),
  .o_dac_seed(o_dac_seed), .o_store_a(o_store_a), .o_store_b(o_store_b));
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic i_clk, i_rst, i_wr, i_rd, i_slot_sel, rd_d, o_cal_busy, o_store_a, o_store_b;
  logic [7:0] i_addr, i_wdata, o_rdata, o_cp_scale;
  logic [1:0] o_pre_swing, o_pre_current;
  logic [2:0] o_rx_swing, o_tx_swing, o_rx_current, o_tx_current, o_dac_seed;
  logic [7:0] rd_q[$];
  logic [1:0] st_q[$];
  logic [7:0] rv[6] = '{8'he1, 8'h65, 8'h86, 8'h05, 8'h00, 8'h00};
  int waits[4] = '{4, 5, 6, 8};
  int err_total, compares, busy_n;
  lbp_host lbp_host_i (.i_clk(i_clk), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr),
    .o_rd(i_rd), .o_slot_sel(i_slot_sel));
  // short counts keep each run to about 8 to 16 cycles
  lbp_regs #(.REF_DIV(2), .WAIT0(4), .WAIT1(5), .WAIT2(6), .WAIT3(8)) lbp_regs_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_slot_sel(i_slot_sel), .o_rdata(o_rdata), .o_pre_swing(o_pre_swing),
    .o_rx_swing(o_rx_swing), .o_tx_swing(o_tx_swing), .o_pre_current(o_pre_current),
    .o_rx_current(o_rx_current), .o_tx_current(o_tx_current), .o_cp_scale(o_cp_scale),
    .o_cal_busy(o_cal_busy), .o_dac_seed(o_dac_seed),
    .o_store_a(o_store_a), .o_store_b(o_store_b));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    lbp_host_i.rd(a);
  endtask
  always @(posedge i_clk) begin
    rd_d <= i_rd;
    if (rd_d === 1'b1) chk(o_rdata, rd_q.pop_front());
    if ((o_store_a | o_store_b) === 1'b1) chk({6'h0, o_store_a, o_store_b}, {6'h0, st_q.pop_front()});
    if (o_cal_busy === 1'b1) busy_n++;
  end
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    #25000;
    err_total++;
    stop_test();
  end
  initial begin
    logic [7:0] v;
    logic [7:0] w[3];
    i_rst = 1'b1;
    void'($urandom(81335));
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (rv[k]) rdx(8'(8'h18 + k), rv[k]);
    repeat (4) begin
      for (int k = 0; k < 3; k++) begin
        v = 8'($urandom);
        w[k] = v;
        lbp_host_i.wr(8'(8'h18 + k), v);
        rdx(8'(8'h18 + k), v);
      end
      lbp_host_i.wr(8'h1d, 8'($urandom));
      rdx(8'h1d, 8'h00);
      @(negedge i_clk);
      chk({o_pre_swing, o_rx_swing, o_tx_swing}, w[0]);
      chk({o_pre_current, o_rx_current, o_tx_current}, w[1]);
      chk(o_cp_scale, w[2]);
    end
    for (int m = 0; m < 16; m++) begin
      v = {1'b0, m[0], m[2:1], 1'b1, 3'($urandom)};
      lbp_host_i.o_slot_sel <= m[3];
      lbp_host_i.wr(8'h1b, v);
      v[7] = 1'b1;
      lbp_host_i.wr(8'h1b, v);
      busy_n = 0;
      st_q.push_back(m[0] ? 2'b11 : (m[3] ? 2'b01 : 2'b10));
      rdx(8'h1b, v & 8'hf7);
      rdx(8'h1c, 8'h01);
      lbp_host_i.idle(1);
      while (o_cal_busy === 1'b1 && busy_n < 60) @(posedge i_clk);
      lbp_host_i.idle(2);
      chk(8'(busy_n >= waits[m[2:1]] * 2 - 1 && busy_n <= waits[m[2:1]] * 2 + 1), 8'h01);
      lbp_host_i.wr(8'h1b, v);
      lbp_host_i.idle(3);
      chk({7'h0, o_cal_busy}, 8'h00);
      chk({5'h0, o_dac_seed}, {5'h0, v[2:0]});
      chk(8'(st_q.size()), 8'h00);
    end
    chk(8'(rd_q.size()), 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
